//--- pkg/utp_regs.svh
`ifndef UTP_REGS_SVH
`define UTP_REGS_SVH

// system clock and link clock periods in ns
`define UTP_CLK_NS 50
`define UTP_LINK_NS 400
// half link period in system clock cycles
`define UTP_LINK_HALF (`UTP_LINK_NS / (2 * `UTP_CLK_NS))
// shortest legal link period in ns for 8-bit (50 MHz) and 16-bit (33 MHz) mode
`define UTP_MIN_NS_8 20
`define UTP_MIN_NS_16 31
// words per cell in 16-bit mode, bytes per cell in 8-bit mode
`define UTP_CELL_W16 6'h1b
`define UTP_CELL_W8 6'h35
// address that no port may own
`define UTP_NULL_ADDR 5'h1f

`endif

//--- pkg/utp_pkg.sv
package utp_pkg;
`include "utp_regs.svh"

    typedef logic [15:0] utp_word_t;
    typedef logic [5:0] utp_cnt_t;

    // transfer states, one bit so gray order is trivial
    typedef enum logic [0:0] {UTP_IDLE = 1'b0, UTP_CELL = 1'b1} utp_xfer_e;

    // phy end state
    typedef struct packed {
        logic [2:0] txck;
        logic [23:0] tx_s1;
        logic [23:0] tx_s2;
        logic [23:0] tx_s3;
        logic [2:0] rxck;
        logic [5:0] rx_s1;
        logic [5:0] rx_s2;
        logic [5:0] rx_s3;
        utp_xfer_e tx_st;
        utp_cnt_t tx_cnt;
        logic tx_sel;
        logic tx_clav;
        logic tx_clav_oe;
        utp_word_t up_word;
        logic up_valid;
        logic up_sof;
        logic up_perr;
        logic rx_sel;
        utp_cnt_t rx_cnt;
        logic rx_clav;
        logic rx_clav_oe;
        utp_word_t rx_data;
        logic rx_par;
        logic rx_soc;
        logic rx_oe;
        logic rx_take;
    } utp_dev_s;

    // atm end state
    typedef struct packed {
        logic [3:0] div;
        logic lclk;
        logic [19:0] in_s1;
        logic [19:0] in_s2;
        utp_xfer_e tx_st;
        utp_cnt_t tx_cnt;
        logic tx_polled;
        utp_word_t tx_data;
        logic tx_par;
        logic tx_soc;
        logic tx_enb_n;
        logic tx_take;
        utp_xfer_e rx_st;
        utp_cnt_t rx_req;
        utp_cnt_t rx_got;
        logic rx_polled;
        logic rx_enb_n;
        utp_word_t up_word;
        logic up_valid;
        logic up_sof;
        logic up_perr;
    } utp_host_s;

    // clear the upper byte in 8-bit mode
    function automatic utp_word_t utp_mask(input utp_word_t w, input logic wide);
        return wide ? w : {8'h00, w[7:0]};
    endfunction

    // parity bit for an already masked word
    function automatic logic utp_par(input utp_word_t w, input logic odd);
        return odd ? ~(^w) : (^w);
    endfunction

    // words of one cell for the current mode
    function automatic utp_cnt_t utp_len(input logic wide);
        return wide ? `UTP_CELL_W16 : `UTP_CELL_W8;
    endfunction

endpackage

//--- pkg/utp_if.sv
`timescale 1ns/1ps
interface utp_if;
    logic tx_clk;
    logic [15:0] tx_data;
    logic tx_par;
    logic tx_soc;
    logic tx_enb_n;
    logic [4:0] tx_addr;
    logic tx_clav_o;
    logic tx_clav_oe;
    logic tx_clav;
    logic rx_clk;
    logic rx_enb_n;
    logic [4:0] rx_addr;
    logic [15:0] rx_data_o;
    logic rx_par_o;
    logic rx_soc_o;
    logic rx_oe;
    logic [15:0] rx_data;
    logic rx_par;
    logic rx_soc;
    logic rx_clav_o;
    logic rx_clav_oe;
    logic rx_clav;

    // undriven shared lines settle low, as with the pull-downs on the board
    assign tx_clav = tx_clav_oe & tx_clav_o;
    assign rx_clav = rx_clav_oe & rx_clav_o;
    assign rx_data = rx_oe ? rx_data_o : 16'h0000;
    assign rx_par = rx_oe & rx_par_o;
    assign rx_soc = rx_oe & rx_soc_o;

    modport phy (
        input tx_clk, tx_data, tx_par, tx_soc, tx_enb_n, tx_addr,
        output tx_clav_o, tx_clav_oe,
        input rx_clk, rx_enb_n, rx_addr,
        output rx_data_o, rx_par_o, rx_soc_o, rx_oe, rx_clav_o, rx_clav_oe
    );

    modport atm (
        output tx_clk, tx_data, tx_par, tx_soc, tx_enb_n, tx_addr,
        input tx_clav,
        output rx_clk, rx_enb_n, rx_addr,
        input rx_data, rx_par, rx_soc, rx_clav
    );
endinterface

//--- rtl/utp_phy_port.sv
`timescale 1ns/1ps
module utp_phy_port
    import utp_pkg::*;
#(
    parameter logic [4:0] PHY_ADDR = 5'h00
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wide_mode,
    input wire logic odd_par,
    input wire logic tx_space,
    output logic [15:0] tx_word,
    output logic tx_valid,
    output logic tx_sof,
    output logic tx_perr,
    input wire logic rx_avail,
    input wire logic [15:0] rx_word,
    output logic rx_take,
    utp_if.phy link
);

    ////////////////////////////////////////////////////////////////////////////
    // elaboration check

    generate
        if (PHY_ADDR == `UTP_NULL_ADDR)
        begin : g_addr_chk
            $error("utp_phy_port: port address must not be the null address");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // state

    utp_dev_s q;
    utp_dev_s d;
    logic tx_rise;
    logic rx_rise;
    utp_word_t t_data;
    logic t_par;
    logic t_soc;
    logic t_enb_n;
    logic [4:0] t_addr;
    logic r_enb_n;
    logic [4:0] r_addr;
    utp_word_t t_word;
    utp_word_t r_word;
    utp_cnt_t len;

    // link clock edges; data is taken from the stage one older than the edge
    // so a word that changes with the clock is seen at its old value
    assign tx_rise = q.txck[1] & ~q.txck[2];
    assign rx_rise = q.rxck[1] & ~q.rxck[2];
    assign {t_data, t_par, t_soc, t_enb_n, t_addr} = q.tx_s3;
    assign {r_enb_n, r_addr} = q.rx_s3;
    assign t_word = utp_mask(t_data, wide_mode);
    assign r_word = utp_mask(rx_word, wide_mode);
    assign len = utp_len(wide_mode);

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        d = q;
        // two-stage synchronisers plus one history stage
        d.txck = {q.txck[1:0], link.tx_clk};
        d.tx_s1 = {link.tx_data, link.tx_par, link.tx_soc, link.tx_enb_n, link.tx_addr};
        d.tx_s2 = q.tx_s1;
        d.tx_s3 = q.tx_s2;
        d.rxck = {q.rxck[1:0], link.rx_clk};
        d.rx_s1 = {link.rx_enb_n, link.rx_addr};
        d.rx_s2 = q.rx_s1;
        d.rx_s3 = q.rx_s2;
        d.up_valid = 1'b0;
        d.up_perr = 1'b0;
        d.rx_take = 1'b0;

        // transmit direction: poll answer, selection and cell intake
        if (tx_rise)
        begin
            // answer a poll of our own address only, with a whole-cell view
            d.tx_clav_oe = (t_addr == PHY_ADDR);
            d.tx_clav = (t_addr == PHY_ADDR) & tx_space;
            if (t_enb_n)
            begin
                // selection is latched while enable is idle
                d.tx_sel = (t_addr == PHY_ADDR);
            end
            else if (q.tx_sel)
            begin
                if (t_soc)
                begin
                    // a start always opens a new cell
                    d.tx_st = UTP_CELL;
                    d.tx_cnt = 6'h01;
                    d.up_word = t_word;
                    d.up_valid = 1'b1;
                    d.up_sof = 1'b1;
                    d.up_perr = (utp_par(t_word, odd_par) != t_par);
                end
                else if (q.tx_st == UTP_CELL)
                begin
                    d.tx_cnt = q.tx_cnt + 6'h01;
                    d.up_word = t_word;
                    d.up_valid = 1'b1;
                    d.up_sof = 1'b0;
                    d.up_perr = (utp_par(t_word, odd_par) != t_par);
                    if (q.tx_cnt + 6'h01 == len)
                    begin
                        d.tx_st = UTP_IDLE;
                    end
                end
                // words outside a cell fall here and are dropped
            end
        end

        // receive direction: poll answer, selection and word output
        if (rx_rise)
        begin
            // no view of the next cell while one is still in flight
            d.rx_clav_oe = (r_addr == PHY_ADDR);
            d.rx_clav = (r_addr == PHY_ADDR) & rx_avail & (q.rx_cnt == 6'h00);
            if (r_enb_n)
            begin
                d.rx_sel = (r_addr == PHY_ADDR);
                d.rx_oe = 1'b0;
                d.rx_soc = 1'b0;
            end
            else if (q.rx_sel)
            begin
                // drive for the cycle after the enabled one
                d.rx_oe = 1'b1;
                if (q.rx_cnt != 6'h00 || rx_avail)
                begin
                    d.rx_data = r_word;
                    d.rx_par = utp_par(r_word, odd_par);
                    d.rx_soc = (q.rx_cnt == 6'h00);
                    d.rx_take = 1'b1;
                    d.rx_cnt = (q.rx_cnt + 6'h01 == len) ? 6'h00 : q.rx_cnt + 6'h01;
                end
                else
                begin
                    d.rx_soc = 1'b0;
                end
            end
            else
            begin
                d.rx_oe = 1'b0;
                d.rx_soc = 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    // synchronous reset; all fields come up idle and undriven
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    // every output is a plain state field
    assign tx_word = q.up_word;
    assign tx_valid = q.up_valid;
    assign tx_sof = q.up_sof;
    assign tx_perr = q.up_perr;
    assign rx_take = q.rx_take;
    assign link.tx_clav_o = q.tx_clav;
    assign link.tx_clav_oe = q.tx_clav_oe;
    assign link.rx_data_o = q.rx_data;
    assign link.rx_par_o = q.rx_par;
    assign link.rx_soc_o = q.rx_soc;
    assign link.rx_oe = q.rx_oe;
    assign link.rx_clav_o = q.rx_clav;
    assign link.rx_clav_oe = q.rx_clav_oe;

endmodule

//--- rtl/utp_atm_port.sv
`timescale 1ns/1ps
module utp_atm_port
    import utp_pkg::*;
#(
    parameter logic [4:0] PHY_ADDR = 5'h00,
    parameter int HALF = `UTP_LINK_HALF
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wide_mode,
    input wire logic odd_par,
    input wire logic [15:0] tx_word,
    input wire logic tx_valid,
    input wire logic tx_sof,
    output logic tx_take,
    output logic [15:0] rx_word,
    output logic rx_valid,
    output logic rx_sof,
    output logic rx_perr,
    utp_if.atm link
);

    ////////////////////////////////////////////////////////////////////////////
    // elaboration check

    // the link must stay within the 16-bit rate limit and leave room to sync
    generate
        if (HALF < 4 || HALF > 15 || 2 * HALF * `UTP_CLK_NS < `UTP_MIN_NS_16)
        begin : g_half_chk
            $error("utp_atm_port: HALF out of range");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // state

    utp_host_s q;
    utp_host_s d;
    logic rise;
    logic clav_tx;
    logic clav_rx;
    utp_word_t in_data;
    logic in_par;
    logic in_soc;
    utp_word_t w_tx;
    utp_word_t w_rx;
    utp_cnt_t len;

    // the link clock rises on the system clock edge that ends the cycle this flag is set
    assign rise = (q.div == 4'(HALF - 1)) & ~q.lclk;
    assign {clav_tx, clav_rx, in_par, in_soc, in_data} = q.in_s2;
    assign w_tx = utp_mask(tx_word, wide_mode);
    assign w_rx = utp_mask(in_data, wide_mode);
    assign len = utp_len(wide_mode);

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        d = q;
        // link clock divider
        d.div = (q.div == 4'(HALF - 1)) ? 4'h0 : q.div + 4'h1;
        if (q.div == 4'(HALF - 1))
        begin
            d.lclk = ~q.lclk;
        end
        d.in_s1 = {link.tx_clav, link.rx_clav, link.rx_par, link.rx_soc, link.rx_data};
        d.in_s2 = q.in_s1;
        d.tx_take = 1'b0;
        d.up_valid = 1'b0;
        d.up_perr = 1'b0;

        if (rise)
        begin
            // transmit: poll, then send one cell
            d.tx_soc = 1'b0;
            d.tx_enb_n = 1'b1;
            unique case (q.tx_st)
                UTP_IDLE:
                begin
                    d.tx_polled = 1'b1;
                    if (tx_valid && !tx_sof)
                    begin
                        d.tx_take = 1'b1; // stray word, resync to a start
                    end
                    else if (q.tx_polled && clav_tx && tx_valid)
                    begin
                        d.tx_st = UTP_CELL;
                        d.tx_enb_n = 1'b0;
                        d.tx_soc = 1'b1;
                        d.tx_data = w_tx;
                        d.tx_par = utp_par(w_tx, odd_par);
                        d.tx_take = 1'b1;
                        d.tx_cnt = 6'h01;
                    end
                end
                UTP_CELL:
                begin
                    if (q.tx_cnt == len)
                    begin
                        d.tx_st = UTP_IDLE;
                        d.tx_polled = 1'b0;
                    end
                    else if (tx_valid)
                    begin
                        // a gap in user data holds enable high
                        d.tx_enb_n = 1'b0;
                        d.tx_data = w_tx;
                        d.tx_par = utp_par(w_tx, odd_par);
                        d.tx_take = 1'b1;
                        d.tx_cnt = q.tx_cnt + 6'h01;
                    end
                end
            endcase

            // receive: poll, then pull one cell
            unique case (q.rx_st)
                UTP_IDLE:
                begin
                    d.rx_polled = 1'b1;
                    d.rx_enb_n = 1'b1;
                    if (q.rx_polled && clav_rx)
                    begin
                        d.rx_st = UTP_CELL;
                        d.rx_enb_n = 1'b0;
                        d.rx_req = 6'h01;
                        d.rx_got = 6'h00;
                    end
                end
                UTP_CELL:
                begin
                    // a word lands two rises after its enabled rise: the phy
                    // sees the enable one rise late, then drives for a cycle
                    if (q.rx_req != 6'h01)
                    begin
                        d.up_word = w_rx;
                        d.up_valid = 1'b1;
                        d.up_sof = in_soc;
                        d.up_perr = (utp_par(w_rx, odd_par) != in_par);
                        d.rx_got = q.rx_got + 6'h01;
                    end
                    d.rx_enb_n = (q.rx_req == len);
                    if (q.rx_req != len)
                    begin
                        d.rx_req = q.rx_req + 6'h01;
                    end
                    if (q.rx_req != 6'h01 && q.rx_got + 6'h01 == len)
                    begin
                        d.rx_st = UTP_IDLE;
                        d.rx_polled = 1'b0;
                        d.rx_enb_n = 1'b1;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    // synchronous reset; enables idle high, address parked on our port
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            q <= '0;
            q.tx_enb_n <= 1'b1;
            q.rx_enb_n <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign tx_take = q.tx_take;
    assign rx_word = q.up_word;
    assign rx_valid = q.up_valid;
    assign rx_sof = q.up_sof;
    assign rx_perr = q.up_perr;
    assign link.tx_clk = q.lclk;
    assign link.rx_clk = q.lclk;
    assign link.tx_data = q.tx_data;
    assign link.tx_par = q.tx_par;
    assign link.tx_soc = q.tx_soc;
    assign link.tx_enb_n = q.tx_enb_n;
    assign link.tx_addr = PHY_ADDR;
    assign link.rx_enb_n = q.rx_enb_n;
    assign link.rx_addr = PHY_ADDR;

endmodule

//--- testbench/utp_link_checker.sv
`timescale 1ns/1ps
module utp_link_checker
    import utp_pkg::*;
#(
    parameter logic [4:0] PHY_ADDR = 5'h00
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wide_mode,
    input wire logic odd_par,
    input wire logic tx_clk,
    input wire logic [15:0] tx_data,
    input wire logic tx_par,
    input wire logic tx_soc,
    input wire logic tx_enb_n,
    input wire logic [4:0] tx_addr,
    input wire logic tx_clav_oe,
    input wire logic rx_clk,
    input wire logic rx_enb_n,
    input wire logic [4:0] rx_addr,
    input wire logic rx_oe,
    input wire logic [15:0] rx_data,
    input wire logic rx_par,
    input wire logic rx_soc,
    input wire logic rx_clav_oe
);
    logic [6:0] tx_cnt_q, rx_cnt_q, enb_age_q, fall_age_q, rise_age_q;
    logic [6:0] cell_len;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    // ages saturate so a long idle stretch never wraps back into the window
    function automatic logic [6:0] sat(input logic [6:0] a);
        return (a == 7'h63) ? a : a + 7'h01;
    endfunction

    assign cell_len = wide_mode ? 7'h1b : 7'h35;

    ////////////////////////////////////////////////////////////////////////////
    // words per cell on each direction and ages since receive events
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            tx_cnt_q <= 7'h00;
            rx_cnt_q <= 7'h00;
            enb_age_q <= 7'h63;
            fall_age_q <= 7'h63;
            rise_age_q <= 7'h63;
        end
        else
        begin
            if ($rose(tx_clk) && !tx_enb_n)
                tx_cnt_q <= tx_soc ? 7'h01 : tx_cnt_q + 7'h01;
            if ($rose(rx_clk))
                rx_cnt_q <= rx_enb_n ? 7'h00 : rx_cnt_q + 7'h01;
            enb_age_q <= !rx_enb_n ? 7'h00 : sat(enb_age_q);
            fall_age_q <= $fell(rx_enb_n) ? 7'h00 : sat(fall_age_q);
            rise_age_q <= $rose(rx_clk) ? 7'h00 : sat(rise_age_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    AST_TX_CELL_LEN: assert property ($rose(tx_enb_n) |-> tx_cnt_q == cell_len)
        else $error("transmit cell length wrong");
    AST_RX_CELL_LEN: assert property ($rose(rx_enb_n) |-> rx_cnt_q == cell_len)
        else $error("receive cell length wrong");
    AST_TX_SOC_ENB: assert property (tx_soc |-> !tx_enb_n)
        else $error("start flag outside enabled cycle");
    AST_TX_PARITY: assert property (!tx_enb_n |->
        tx_par == (odd_par ^ (^(wide_mode ? tx_data : {8'h00, tx_data[7:0]}))))
        else $error("transmit parity wrong");
    AST_RX_PARITY: assert property (rx_oe |->
        rx_par == (odd_par ^ (^(wide_mode ? rx_data : {8'h00, rx_data[7:0]}))))
        else $error("receive parity wrong");
    AST_RX_NARROW: assert property (rx_oe && !wide_mode |-> rx_data[15:8] == 8'h00)
        else $error("upper receive byte driven in byte mode");
    // the phy lets go one link period plus its sync delay after enable rises
    AST_RX_OE_ENB: assert property (rx_oe |-> enb_age_q <= 7'h0a && rx_addr == PHY_ADDR)
        else $error("receive bus driven without enable");
    AST_RX_SOC_FIRST: assert property ($rose(rx_soc) |-> fall_age_q <= 7'h14)
        else $error("receive start flag not on first word");
    AST_RX_PRESENT: assert property ($fell(rx_enb_n) |-> ##[1:20] rx_oe)
        else $error("receive data not presented");
    AST_TX_CLAV_OE: assert property ($rose(tx_clk) && tx_addr == PHY_ADDR
        |-> ##[1:5] tx_clav_oe)
        else $error("transmit cell available not driven");
    AST_RX_CLAV_OE: assert property ($rose(rx_clk) && rx_addr == PHY_ADDR
        |-> ##[1:5] rx_clav_oe)
        else $error("receive cell available not driven");
    AST_RX_CHANGE: assert property ($changed(rx_data) |-> rise_age_q <= 7'h05)
        else $error("receive data changed away from clock rise");
    // each link clock phase lasts two system cycles or more, well under the rate limit
    AST_LINK_RATE: assert property ($changed(tx_clk) |=> $stable(tx_clk))
        else $error("link clock too fast");
endmodule

//--- testbench/utopia_phy_cell_port_tb.sv
`timescale 1ns/1ps
module utopia_phy_cell_port_tb;
    import utp_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic wide_mode = 1'b1;
    logic odd_par = 1'b1;
    logic tx_space = 1'b0;
    logic rx_avail = 1'b0;
    logic [15:0] rx_word = 16'h0000;
    logic [15:0] a_tx_word = 16'h0000;
    logic a_tx_valid = 1'b0;
    logic a_tx_sof = 1'b0;
    logic [15:0] p_tx_word, a_rx_word;
    logic p_tx_valid, p_tx_sof, p_tx_perr, p_rx_take;
    logic a_tx_take, a_rx_valid, a_rx_sof, a_rx_perr;
    logic [16:0] tx_q[$];
    logic [16:0] rx_q[$];
    int bad_count = 0;
    int n_tests = 0;
    integer seed = 56;

    utp_if i_utp_if();

    utp_phy_port i_utp_phy_port (.clk(clk), .sys_rst(sys_rst), .wide_mode(wide_mode),
        .odd_par(odd_par), .tx_space(tx_space), .tx_word(p_tx_word), .tx_valid(p_tx_valid),
        .tx_sof(p_tx_sof), .tx_perr(p_tx_perr), .rx_avail(rx_avail), .rx_word(rx_word),
        .rx_take(p_rx_take), .link(i_utp_if.phy));

    utp_atm_port i_utp_atm_port (.clk(clk), .sys_rst(sys_rst), .wide_mode(wide_mode),
        .odd_par(odd_par), .tx_word(a_tx_word), .tx_valid(a_tx_valid), .tx_sof(a_tx_sof),
        .tx_take(a_tx_take), .rx_word(a_rx_word), .rx_valid(a_rx_valid), .rx_sof(a_rx_sof),
        .rx_perr(a_rx_perr), .link(i_utp_if.atm));

    utp_link_checker i_utp_link_checker (.clk(clk), .sys_rst(sys_rst),
        .wide_mode(wide_mode), .odd_par(odd_par), .tx_clk(i_utp_if.tx_clk),
        .tx_data(i_utp_if.tx_data), .tx_par(i_utp_if.tx_par), .tx_soc(i_utp_if.tx_soc),
        .tx_enb_n(i_utp_if.tx_enb_n), .tx_addr(i_utp_if.tx_addr),
        .tx_clav_oe(i_utp_if.tx_clav_oe), .rx_clk(i_utp_if.rx_clk),
        .rx_enb_n(i_utp_if.rx_enb_n), .rx_addr(i_utp_if.rx_addr), .rx_oe(i_utp_if.rx_oe),
        .rx_data(i_utp_if.rx_data), .rx_par(i_utp_if.rx_par), .rx_soc(i_utp_if.rx_soc),
        .rx_clav_oe(i_utp_if.rx_clav_oe));

    ////////////////////////////////////////////////////////////////////////////
    // 50 ns system clock
    always #25 clk = ~clk;

    task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        if (bad_count == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // outputs are compared against the oldest note; an empty queue means a stray word
    always @(posedge clk)
    begin
        if (!sys_rst && p_tx_valid === 1'b1)
        begin
            if (tx_q.size() == 0)
                chk({p_tx_sof, p_tx_word}, 17'h1ffff);
            else
                chk({p_tx_sof, p_tx_word}, tx_q.pop_front());
            chk({16'h0000, p_tx_perr}, 17'h00000);
        end
        if (!sys_rst && a_rx_valid === 1'b1)
        begin
            if (rx_q.size() == 0)
                chk({a_rx_sof, a_rx_word}, 17'h1ffff);
            else
                chk({a_rx_sof, a_rx_word}, rx_q.pop_front());
            chk({16'h0000, a_rx_perr}, 17'h00000);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // one mode: reset, hold both users back, then two cells each way at once
    task automatic run_mode(input logic wide, input logic odd);
        int len, guard, tk, tn, rn;
        len = wide ? 27 : 53;
        sys_rst <= 1'b1;
        wide_mode <= wide;
        odd_par <= odd;
        tx_space <= 1'b0;
        rx_avail <= 1'b0;
        // a cell is offered from the start so the hold-back check can trip
        a_tx_valid <= 1'b1;
        a_tx_sof <= 1'b1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        tk = 0;
        // no room and no cell: nothing may cross either way
        for (guard = 0; guard < 100; guard++)
        begin
            @(posedge clk);
            if (a_tx_take !== 1'b0 || p_rx_take !== 1'b0)
                tk++;
        end
        chk(17'(tk), 17'h00000);
        tx_space <= 1'b1;
        rx_avail <= 1'b1;
        a_tx_word <= 16'($random(seed));
        rx_word <= 16'($random(seed));
        tn = 0;
        rn = 0;
        for (guard = 0; guard < 4000 && (tn < 2 * len || rn < 2 * len); guard++)
        begin
            @(posedge clk);
            if (a_tx_take === 1'b1 && tn < 2 * len)
            begin
                tx_q.push_back({a_tx_sof, wide ? a_tx_word : {8'h00, a_tx_word[7:0]}});
                tn++;
                a_tx_sof <= (tn % len == 0);
                a_tx_word <= 16'($random(seed));
                if (tn == 2 * len)
                    a_tx_valid <= 1'b0;
            end
            if (p_rx_take === 1'b1 && rn < 2 * len)
            begin
                rx_q.push_back({rn % len == 0, wide ? rx_word : {8'h00, rx_word[7:0]}});
                rn++;
                rx_word <= 16'($random(seed));
                if (rn == 2 * len)
                    rx_avail <= 1'b0;
            end
        end
        if (guard >= 4000)
        begin
            bad_count++;
            stop_test();
        end
        // let the last words arrive, bounded
        for (guard = 0; guard < 100 && (tx_q.size() != 0 || rx_q.size() != 0); guard++)
            @(posedge clk);
        chk(17'(tx_q.size() + rx_q.size()), 17'h00000);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // both widths and both parity senses, with a reset between each
    initial
    begin
        run_mode(1'b1, 1'b1);
        run_mode(1'b0, 1'b0);
        run_mode(1'b1, 1'b0);
        stop_test();
    end
endmodule
